//--- usb_ep_mode_defines.vh
// Constants for the endpoint mode responder: mode encodings, field positions,
// response codes and reset values. Assumes inclusion by bare name.
// Operation
// - One shared 4-bit mode code per endpoint
// - Mode 0000 answers nothing at all
// - Control endpoint ACKed SETUP forces mode 0001
// - Mode 1011 ACKed OUT becomes 0001
// - Mode 1001 ACKed OUT becomes 1000
// - Mode 1101 host ACK becomes 1100
// - Mode 1111 host ACK becomes 1110
// - Stall bit 7 on data endpoint modes
// - Mode 1001: OUT ACK or STALL only
// - Mode 1101: IN count or STALL only
// - Check: ACK zero-length DATA1, else STALL/ignore
// - Count response sends 4-bit count bytes
// - Reset disables all; disabled stays disabled until a firmware write
`ifndef USB_EP_MODE_DEFINES_VH
`define USB_EP_MODE_DEFINES_VH

// Mode encodings
`define MODE_DISABLE 4'h0
`define MODE_NAK_IN_OUT 4'h1
`define MODE_STATUS_OUT 4'h2
`define MODE_STALL_IN_OUT 4'h3
`define MODE_IGNORE_IN_OUT 4'h4
`define MODE_STATUS_IN 4'h6
`define MODE_NAK_OUT 4'h8
`define MODE_ACK_OUT 4'h9
`define MODE_NAK_OUT_STAT_IN 4'hA
`define MODE_ACK_OUT_NAK_IN 4'hB
`define MODE_NAK_IN 4'hC
`define MODE_ACK_IN 4'hD
`define MODE_NAK_IN_STAT_OUT 4'hE
`define MODE_ACK_IN_STAT_OUT 4'hF
`define MODE_RESET 4'h0

// Mode register layout
`define MODE_LSB 0
`define MODE_MSB 3
`define STALL_BIT 7

// Token type codes
`define TOK_SETUP 2'h1
`define TOK_IN 2'h2
`define TOK_OUT 2'h3

// Response codes
`define RSP_IGNORE 3'h0
`define RSP_ACK 3'h1
`define RSP_NAK 3'h2
`define RSP_STALL 3'h3
`define RSP_TX_ZERO 3'h4
`define RSP_TX_COUNT 3'h5

`endif

//--- usb_endpoint_mode_responder.v
// Endpoint mode responder of the serial_engine: decodes each endpoint's mode
// into a handshake answer per token and rewrites modes after ACK handshakes.
// Assumes tokens, data validity and handshake completion come from engine
// logic on the same clock, so no input synchronisers are needed.
`timescale 1ns/1ps
`include "usb_ep_mode_defines.vh"

module usb_endpoint_mode_responder #(
    parameter NUM_EP = 3,   // control_endpoint plus two data endpoints
    parameter CNT_W = 4     // Width of the transmit byte count
) (
    // Clock and reset
    input wire sys_clk_in,
    input wire nrst_in,
    // Firmware mode writes (endpoint 0 is control_endpoint)
    input wire mode_wr_in,
    input wire [1:0] mode_wr_ep_in,
    input wire [7:0] mode_wr_data_in,
    input wire [CNT_W-1:0] tx_count_in,
    // Token from the engine, one-cycle strobe
    input wire token_vld_in,
    input wire [1:0] token_type_in,
    input wire [1:0] token_ep_in,
    input wire data_valid_in,
    input wire data_zero_len_in,
    input wire data_toggle_in,
    // Handshake complete strobes from the engine
    input wire ack_done_in,
    input wire [1:0] ack_ep_in,
    // Response toward the engine
    output reg rsp_vld_out,
    output reg [2:0] rsp_code_out,
    output reg [1:0] rsp_ep_out,
    output reg [CNT_W-1:0] rsp_count_out,
    // Mode registers as of one cycle earlier, flattened, endpoint 0 in low byte
    output reg [8*NUM_EP-1:0] mode_out
);

    // Mode register per endpoint; bit 7 is stall on data endpoints
    reg [7:0] mode_reg [0:NUM_EP-1];
    // Token type latched so a later ACK knows what it completed
    reg [1:0] last_tok_reg [0:NUM_EP-1];

    // Decode one mode, token and data state into a response code
    function [2:0] decode_rsp;
        input [3:0] mode;
        input stall;
        input [1:0] tok;
        input dval;
        input zlen;
        input dtog;
        reg chk;
        begin
            chk = dval && zlen && dtog;
            decode_rsp = `RSP_IGNORE;
            if (tok == `TOK_SETUP) begin
                // SETUP accepting modes, valid data only
                case (mode)
                    `MODE_NAK_IN_OUT, `MODE_STATUS_OUT, `MODE_STALL_IN_OUT, `MODE_IGNORE_IN_OUT,
                    `MODE_STATUS_IN, `MODE_NAK_OUT_STAT_IN, `MODE_ACK_OUT_NAK_IN,
                    `MODE_NAK_IN_STAT_OUT, `MODE_ACK_IN_STAT_OUT: begin
                        decode_rsp = dval ? `RSP_ACK : `RSP_IGNORE;
                    end
                    default: begin
                        decode_rsp = `RSP_IGNORE;
                    end
                endcase
            end else if (tok == `TOK_IN) begin
                case (mode)
                    `MODE_NAK_IN_OUT, `MODE_ACK_OUT_NAK_IN, `MODE_NAK_IN,
                    `MODE_NAK_IN_STAT_OUT: decode_rsp = `RSP_NAK;
                    `MODE_STATUS_OUT, `MODE_STALL_IN_OUT: decode_rsp = `RSP_STALL;
                    `MODE_STATUS_IN, `MODE_NAK_OUT_STAT_IN: decode_rsp = `RSP_TX_ZERO;
                    `MODE_ACK_IN: begin
                        decode_rsp = stall ? `RSP_STALL : `RSP_TX_COUNT;
                    end
                    `MODE_ACK_IN_STAT_OUT: decode_rsp = `RSP_TX_COUNT;
                    default: decode_rsp = `RSP_IGNORE;
                endcase
            end else if (tok == `TOK_OUT) begin
                case (mode)
                    `MODE_NAK_IN_OUT, `MODE_NAK_OUT,
                    `MODE_NAK_OUT_STAT_IN: decode_rsp = `RSP_NAK;
                    `MODE_STALL_IN_OUT, `MODE_STATUS_IN: decode_rsp = `RSP_STALL;
                    `MODE_ACK_OUT_NAK_IN: decode_rsp = `RSP_ACK;
                    `MODE_ACK_OUT: begin
                        decode_rsp = stall ? `RSP_STALL : `RSP_ACK;
                    end
                    `MODE_STATUS_OUT, `MODE_NAK_IN_STAT_OUT, `MODE_ACK_IN_STAT_OUT: begin
                        // Bad data stays silent, good but non-status gets STALL
                        if (chk) begin
                            decode_rsp = `RSP_ACK;
                        end else if (dval) begin
                            decode_rsp = `RSP_STALL;
                        end else begin
                            decode_rsp = `RSP_IGNORE;
                        end
                    end
                    default: decode_rsp = `RSP_IGNORE;
                endcase
            end
        end
    endfunction

    // Mode after an ACK handshake closes a transaction
    function [3:0] next_mode;
        input [3:0] mode;
        input [1:0] tok;
        input is_ctrl;
        begin
            next_mode = mode;
            if (tok == `TOK_SETUP && is_ctrl && mode != `MODE_DISABLE) begin
                next_mode = `MODE_NAK_IN_OUT;
            end else if (tok == `TOK_OUT && mode == `MODE_ACK_OUT_NAK_IN) begin
                next_mode = `MODE_NAK_IN_OUT;
            end else if (tok == `TOK_OUT && mode == `MODE_ACK_OUT) begin
                next_mode = `MODE_NAK_OUT;
            end else if (tok == `TOK_IN && mode == `MODE_ACK_IN) begin
                next_mode = `MODE_NAK_IN;
            end else if (tok == `TOK_OUT && mode == `MODE_ACK_IN_STAT_OUT) begin
                // Status OUT ACKed in this mode also falls to 1110
                next_mode = `MODE_NAK_IN_STAT_OUT;
            end else if (tok == `TOK_IN && mode == `MODE_ACK_IN_STAT_OUT) begin
                next_mode = `MODE_NAK_IN_STAT_OUT;
            end
        end
    endfunction

    // Per-endpoint mode storage, firmware write versus engine rewrite
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g = g + 1) begin : ep_gen
            wire [7:0] wr_mask;
            // Control endpoint has no stall bit; only data endpoints keep it
            assign wr_mask = (g == 0) ? 8'h0F : 8'h8F;
            always @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    mode_reg[g] <= {4'h0, `MODE_RESET};
                    last_tok_reg[g] <= 2'h0;
                end else begin
                    if (token_vld_in && token_ep_in == g) begin
                        last_tok_reg[g] <= token_type_in;
                    end
                    // Firmware write wins: it is the only way out of disabled
                    if (mode_wr_in && mode_wr_ep_in == g) begin
                        mode_reg[g] <= mode_wr_data_in & wr_mask;
                    end else if (ack_done_in && ack_ep_in == g) begin
                        // Disabled never changes here since next_mode keeps 0000
                        mode_reg[g][3:0] <= next_mode(mode_reg[g][3:0], last_tok_reg[g],
                                                      (g == 0));
                    end
                end
            end
            // Flattened copy for observation, straight from a flop
            always @(posedge sys_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    mode_out[8*g +: 8] <= 8'h00;
                end else begin
                    mode_out[8*g +: 8] <= mode_reg[g];
                end
            end
        end
    endgenerate

    // Selected endpoint mode for the current token
    reg [7:0] sel_mode;
    always @* begin
        if (token_ep_in < NUM_EP) begin
            sel_mode = mode_reg[token_ep_in];
        end else begin
            sel_mode = 8'h00; // Unknown endpoint reads as disabled
        end
    end

    // Registered response, one cycle after the token strobe
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rsp_vld_out <= 1'b0;
            rsp_code_out <= `RSP_IGNORE;
            rsp_ep_out <= 2'h0;
            rsp_count_out <= {CNT_W{1'b0}};
        end else begin
            rsp_vld_out <= token_vld_in;
            if (token_vld_in) begin
                rsp_code_out <= decode_rsp(sel_mode[3:0], sel_mode[`STALL_BIT], token_type_in,
                                           data_valid_in, data_zero_len_in, data_toggle_in);
                rsp_ep_out <= token_ep_in;
                rsp_count_out <= tx_count_in;
            end
        end
    end

endmodule

//--- ep_mode_props.sv
// Checker for the endpoint mode responder, bound to its ports.
// Assumes one clock, and that acks follow an answer by one cycle.
`timescale 1ns/1ps
`include "usb_ep_mode_defines.vh"
module ep_mode_props #(parameter NUM_EP = 3, parameter CNT_W = 4) (
    // Clock, reset and firmware side
    input wire sys_clk_in, input wire nrst_in, input wire mode_wr_in,
    input wire [1:0] mode_wr_ep_in, input wire [7:0] mode_wr_data_in, input wire [CNT_W-1:0] tx_count_in,
    // Engine side
    input wire token_vld_in, input wire [1:0] token_type_in, input wire [1:0] token_ep_in,
    input wire data_valid_in, input wire data_zero_len_in, input wire data_toggle_in,
    input wire ack_done_in, input wire [1:0] ack_ep_in,
    // Outputs watched
    input wire rsp_vld_out, input wire [2:0] rsp_code_out, input wire [1:0] rsp_ep_out,
    input wire [CNT_W-1:0] rsp_count_out, input wire [8*NUM_EP-1:0] mode_out
);
default clocking cb @(posedge sys_clk_in); endclocking
default disable iff (!nrst_in);
// Quiet cycles since a write or ack; mode_out lags, so it is trusted only at 3
reg [1:0] calm_reg;
always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) calm_reg <= 2'h0;
    else if (mode_wr_in || ack_done_in) calm_reg <= 2'h0;
    else if (calm_reg != 2'h3) calm_reg <= calm_reg + 2'h1;
end
wire [3:0] tok_mode = mode_out[8*token_ep_in +: 4];
wire tok_stall = mode_out[8*token_ep_in + 7];
wire [3:0] ack_mode = mode_out[8*ack_ep_in +: 4];
wire tok_ok = token_vld_in && calm_reg == 2'h3;
// Mode expected after an ACK on a data endpoint
function [3:0] next_mode(input [3:0] m);
    case (m)
        4'h9: next_mode = 4'h8;
        4'hB: next_mode = 4'h1;
        4'hD: next_mode = 4'hC;
        4'hF: next_mode = 4'hE;
        default: next_mode = m;
    endcase
endfunction
rsp_answer_a: assert property (token_vld_in |=> rsp_vld_out && rsp_ep_out == $past(token_ep_in))
    else $error("token got no answer");
rsp_cause_a: assert property (rsp_vld_out |-> $past(token_vld_in))
    else $error("answer without token");
count_copy_a: assert property (rsp_vld_out && rsp_code_out == `RSP_TX_COUNT |-> rsp_count_out == $past(tx_count_in))
    else $error("wrong byte count");
disabled_quiet_a: assert property (tok_ok && tok_mode == 4'h0 |=> rsp_code_out == `RSP_IGNORE)
    else $error("disabled endpoint answered");
setup_accept_a: assert property (tok_ok && token_type_in == `TOK_SETUP && data_valid_in
    && tok_mode inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB, 4'hE, 4'hF} |=> rsp_code_out == `RSP_ACK)
    else $error("setup not accepted");
stall_bit_a: assert property (tok_ok && token_ep_in != 2'h0 && tok_stall && ((tok_mode == 4'h9
    && token_type_in == `TOK_OUT) || (tok_mode == 4'hD && token_type_in == `TOK_IN)) |=> rsp_code_out == `RSP_STALL)
    else $error("stall bit not honoured");
ack_rewrite_a: assert property (ack_done_in && calm_reg == 2'h3 && ack_ep_in != 2'h0
    |-> ##3 mode_out[8*$past(ack_ep_in, 3) +: 4] == next_mode($past(ack_mode, 3)))
    else $error("mode not rewritten after ack");
ctrl_setup_a: assert property (rsp_vld_out && rsp_ep_out == 2'h0 && rsp_code_out == `RSP_ACK
    && $past(token_type_in) == `TOK_SETUP ##1 ack_done_in && ack_ep_in == 2'h0 |-> ##3 mode_out[3:0] == 4'h1)
    else $error("control mode not forced after setup");
endmodule
bind usb_endpoint_mode_responder ep_mode_props #(.NUM_EP(NUM_EP), .CNT_W(CNT_W)) chk (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .mode_wr_in(mode_wr_in), .mode_wr_ep_in(mode_wr_ep_in),
    .mode_wr_data_in(mode_wr_data_in), .tx_count_in(tx_count_in), .token_vld_in(token_vld_in),
    .token_type_in(token_type_in), .token_ep_in(token_ep_in), .data_valid_in(data_valid_in),
    .data_zero_len_in(data_zero_len_in), .data_toggle_in(data_toggle_in), .ack_done_in(ack_done_in),
    .ack_ep_in(ack_ep_in), .rsp_vld_out(rsp_vld_out), .rsp_code_out(rsp_code_out), .rsp_ep_out(rsp_ep_out),
    .rsp_count_out(rsp_count_out), .mode_out(mode_out));

//--- usb_host_model.sv
// Host side model: issues tokens and ACK handshakes as engine strobes.
// Assumes the bench calls its tasks; changes land on falling edges.
`timescale 1ns/1ps
module usb_host_model (
    input wire sys_clk_in,
    output reg tok_vld_out, output reg [1:0] tok_type_out, output reg [1:0] tok_ep_out,
    output reg dat_vld_out, output reg dat_zero_out, output reg dat_tog_out,
    output reg ack_out, output reg [1:0] ack_ep_out
);
initial {tok_vld_out, tok_type_out, tok_ep_out, dat_vld_out, dat_zero_out, dat_tog_out, ack_out, ack_ep_out} = 0;
// One-cycle token; qualifiers flip afterwards so stale values cannot help
task tok(input [1:0] t, input [1:0] e, input v, input z, input d);
    @(negedge sys_clk_in) {tok_vld_out, tok_type_out, tok_ep_out, dat_vld_out, dat_zero_out, dat_tog_out} = {1'b1, t, e, v, z, d};
    @(negedge sys_clk_in) {tok_vld_out, tok_type_out, tok_ep_out, dat_vld_out, dat_zero_out, dat_tog_out} = {1'b0, ~t, ~e, ~v, ~z, ~d};
endtask
// One-cycle ACK handshake on an endpoint
task ack(input [1:0] e);
    @(negedge sys_clk_in) {ack_out, ack_ep_out} = {1'b1, e};
    @(negedge sys_clk_in) {ack_out, ack_ep_out} = {1'b0, ~e};
endtask
endmodule

//--- tb.sv
// Bench for the endpoint mode responder: mode tables, rewrites, stall bit.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`include "usb_ep_mode_defines.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin fail_count = fail_count + 1; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb;
reg sys_clk_in = 1'b0;
reg nrst_in = 1'b0;
reg wr = 1'b0;
reg [1:0] wep = 2'h0;
reg [7:0] wd = 8'h00;
reg [3:0] tc = 4'h5;
wire tv, dv, dz, dt, ad, rv;
wire [1:0] tt, te, ae, re;
wire [2:0] rc;
wire [3:0] rn;
wire [23:0] mo;
integer fail_count = 0;
integer checks = 0;
usb_host_model host (.sys_clk_in(sys_clk_in), .tok_vld_out(tv), .tok_type_out(tt), .tok_ep_out(te),
    .dat_vld_out(dv), .dat_zero_out(dz), .dat_tog_out(dt), .ack_out(ad), .ack_ep_out(ae));
// Byte count is driven by the bench so its copy into the answer can be seen to follow it
usb_endpoint_mode_responder uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .mode_wr_in(wr),
    .mode_wr_ep_in(wep), .mode_wr_data_in(wd), .tx_count_in(tc), .token_vld_in(tv), .token_type_in(tt),
    .token_ep_in(te), .data_valid_in(dv), .data_zero_len_in(dz), .data_toggle_in(dt), .ack_done_in(ad),
    .ack_ep_in(ae), .rsp_vld_out(rv), .rsp_code_out(rc), .rsp_ep_out(re), .rsp_count_out(rn), .mode_out(mo));
initial forever #2.5 sys_clk_in = ~sys_clk_in;
task stop_test;
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
// Firmware write, then quiet cycles so the new mode is settled
task wrm(input [1:0] e, input [7:0] d);
    @(negedge sys_clk_in) {wr, wep, wd} = {1'b1, e, d};
    @(negedge sys_clk_in) wr = 1'b0;
    repeat (3) @(negedge sys_clk_in);
endtask
task go(input [1:0] t, input [1:0] e, input z, input d, input [2:0] c);
    host.tok(t, e, 1'b1, z, d);
    @(posedge sys_clk_in) #1;
    `CHK(rc, c)
    `CHK(re, e)
endtask
// ACK, then mode_out shows the rewrite two edges later
task mchk(input [1:0] e, input [3:0] m);
    host.ack(e);
    repeat (2) @(posedge sys_clk_in);
    #1 `CHK(mo[8*e +: 4], m)
endtask
task t_reset;
    `CHK(mo, 24'h0)
    go(`TOK_IN, 2'h1, 1'b0, 1'b0, `RSP_IGNORE);
    mchk(2'h0, 4'h0);
endtask
// Every mode on the control endpoint against all three tokens
task t_table;
    integer i;
    reg [15:0] setup_map;
    setup_map = 16'hCC5E;
    for (i = 0; i < 16; i = i + 1) begin
        wrm(2'h0, i[7:0]);
        go(`TOK_SETUP, 2'h0, 1'b0, 1'b0, {2'h0, setup_map[i]});
        go(`TOK_IN, 2'h0, 1'b0, 1'b0, 64'h5252240004003320 >> (4*i));
        go(`TOK_OUT, 2'h0, 1'b1, 1'b1, 64'h1100121203003120 >> (4*i));
    end
endtask
task t_ctrl;
    wrm(2'h0, 8'h0E);
    go(`TOK_SETUP, 2'h0, 1'b0, 1'b0, `RSP_ACK);
    mchk(2'h0, 4'h1);
endtask
task t_out;
    wrm(2'h1, 8'h09);
    go(`TOK_IN, 2'h1, 1'b0, 1'b0, `RSP_IGNORE);
    go(`TOK_OUT, 2'h1, 1'b0, 1'b0, `RSP_ACK);
    mchk(2'h1, 4'h8);
    wrm(2'h1, 8'h89);
    go(`TOK_OUT, 2'h1, 1'b0, 1'b0, `RSP_STALL);
    wrm(2'h1, 8'h0B);
    go(`TOK_OUT, 2'h1, 1'b0, 1'b0, `RSP_ACK);
    mchk(2'h1, 4'h1);
endtask
task t_in;
    wrm(2'h2, 8'h0D);
    tc = 4'hA;
    go(`TOK_OUT, 2'h2, 1'b0, 1'b0, `RSP_IGNORE);
    go(`TOK_IN, 2'h2, 1'b0, 1'b0, `RSP_TX_COUNT);
    `CHK(rn, 4'hA)
    mchk(2'h2, 4'hC);
    wrm(2'h2, 8'h8D);
    go(`TOK_IN, 2'h2, 1'b0, 1'b0, `RSP_STALL);
endtask
task t_check;
    wrm(2'h1, 8'h0F);
    go(`TOK_OUT, 2'h1, 1'b0, 1'b1, `RSP_STALL);
    go(`TOK_OUT, 2'h1, 1'b1, 1'b0, `RSP_STALL);
    go(`TOK_IN, 2'h1, 1'b0, 1'b0, `RSP_TX_COUNT);
    mchk(2'h1, 4'hE);
endtask
// Watchdog against a hung run
initial begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count = fail_count + 1;
    stop_test;
end
initial begin
    repeat (5) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    t_reset;
    t_table;
    t_ctrl;
    t_out;
    t_in;
    t_check;
    stop_test;
end
endmodule
